// File: rtl/sdc_consts.svh
// Offsets, field positions, reset values and timing counts of the calibration and filter timing block
`ifndef SDC_CONSTS_SVH
`define SDC_CONSTS_SVH
// ****************************************
// Register word offsets
// ****************************************
`define SDC_OFS_MODE    4'h0
`define SDC_OFS_CONF    4'h1
`define SDC_OFS_STAT    4'h2
`define SDC_OFS_DATA    4'h3
`define SDC_OFS_OFFSET  4'h4
`define SDC_OFS_FULL    4'h5
// ****************************************
// Field positions
// ****************************************
`define SDC_MODE_FW_HI  9
`define SDC_MODE_ZLAT   11
`define SDC_MODE_THIRD_ORDER_FILTER_SELECT  15
`define SDC_MODE_OP_HI  23
`define SDC_MODE_OP_LO  21
`define SDC_CONF_CHOP   0
`define SDC_CONF_CLKDIV 1
`define SDC_CONF_GN_HI  4
`define SDC_CONF_GN_LO  2
`define SDC_CONF_CH_HI  11
`define SDC_CONF_CH_LO  8
// ****************************************
// Reset values and timing
// ****************************************
`define SDC_MODE_RST    32'h00000060
`define SDC_CONF_RST    32'h00000000
`define SDC_OFF_RST     24'h800000
`define SDC_FULL_RST    24'h400000
`define SDC_MID_CODE    24'h800000
`define SDC_GAIN_SHIFT  22
`define SDC_DEC_FACTOR  1024
`define SDC_SET_SINC4   5'h04
`define SDC_SET_THIRD_ORDER_FILTER_SELECT   5'h03
`define SDC_SET_CHOP    5'h02
`endif

// File: rtl/sdc_pkg.sv
// Types shared by the calibration and filter timing block
package sdc_pkg;
  typedef enum logic [2:0] {
    SDC_OP_CONT  = 3'h0,
    SDC_OP_SINGLE = 3'h1,
    SDC_OP_IDLE  = 3'h2,
    SDC_OP_PDOWN = 3'h3,
    SDC_OP_IZS   = 3'h4,
    SDC_OP_IFS   = 3'h5,
    SDC_OP_SZS   = 3'h6,
    SDC_OP_SFS   = 3'h7
  } sdc_op_type;

  typedef enum logic [1:0] {
    SDC_ST_IDLE,
    SDC_ST_CONV,
    SDC_ST_CAL,
    SDC_ST_PDOWN
  } sdc_st_type;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } sdc_avs_in_type;

  typedef struct packed {
    sdc_st_type  st_q;
    logic [31:0] mode_q;
    logic [31:0] conf_q;
    logic [23:0] off_q;
    logic [23:0] full_q;
    logic [23:0] data_q;
    logic [19:0] per_q;
    logic [4:0]  left_q;
    logic        ready_n_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [1:0]  ref_q;
    logic        filt_rst_q;
    logic        conv_done_q;
    logic        cs_n_m_q;
    logic        cs_n_s_q;
  } sdc_state_type;
endpackage

// File: rtl/sdc_top.sv
// Calibration sequencer, result scaling and sinc filter output timing with an Avalon-MM register slave
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
`include "sdc_consts.svh"

// Summary of operation
// - Four calibration modes, each selected and started by writing the mode field.
// - Result is raw minus offset, times full-scale coefficient, then stored.
// - Calibration start drives ready bit and ready pin high.
// - Calibration end updates coefficient, clears ready, pin low if selected, goes idle.
// - Internal calibrations route internal zero or full-scale reference to the input.
// - Chop off: zero-scale calibrations last four periods sinc4, three third_order_filter_select.
// - Chop on: zero-scale calibrations last two output periods.
// - Internal full-scale lasts one settling time at gain 1, two otherwise.
// - System full-scale calibration lasts one settling time.
// - Clock-divide bit doubles internal full-scale calibration duration.
// - Coefficients always readable, writable only in idle or power-down.
// - Power-up selects sinc4 filter with chop disabled.
// - Continuous sinc4 output every 1024 times filter word clock cycles.
// - Channel change resets filter; first result after settling, then every period.
// - Single channel keeps converting at programmed rate through input steps.
// - Mode bit 11 gives zero latency: every result waits full settling time.
// - Filter-select bit set to one chooses third_order_filter_select instead of sinc4.
module sdc_top (
  input  wire logic                   CLK,
  input  wire logic                   SRST,
  input  wire sdc_pkg::sdc_avs_in_type AVS_IN,
  output      logic [31:0]            AVS_READDATA,
  output      logic                   AVS_WAITREQUEST,
  input  wire logic [23:0]            RAW_SAMPLE,
  input  wire logic                   CS_N,
  output      logic                   RDY_PIN_O,
  output      logic                   RDY_PIN_OE,
  output      logic [1:0]             REF_SEL,
  output      logic                   FILT_RST,
  output      logic                   CONV_DONE
);
  import sdc_pkg::*;

  sdc_state_type s_q;
  sdc_state_type s_d;

  // ****************************************
  // Decoded settings
  // ****************************************
  logic [9:0]        fw;
  logic [19:0]       per_len;
  sdc_op_type        op;
  logic              chop;
  logic              third_order_filter_select;
  logic              zlat;
  logic              gain_hi;
  logic              clkdiv;
  logic [4:0]        settle;
  logic [4:0]        cal_len;
  logic              tick;
  logic              last;
  logic              acc;
  logic              wr;
  logic              rd;
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [49:0] shf;
  logic [23:0]       scaled;
  logic [31:0]       stat;

  assign fw      = (s_q.mode_q[`SDC_MODE_FW_HI:0] == 10'h000) ? 10'h001 : s_q.mode_q[`SDC_MODE_FW_HI:0];
  assign per_len = {fw, 10'h000};
  assign op      = sdc_op_type'(s_q.mode_q[`SDC_MODE_OP_HI:`SDC_MODE_OP_LO]);
  assign chop    = s_q.conf_q[`SDC_CONF_CHOP];
  assign third_order_filter_select   = s_q.mode_q[`SDC_MODE_THIRD_ORDER_FILTER_SELECT];
  assign zlat    = s_q.mode_q[`SDC_MODE_ZLAT];
  assign gain_hi = s_q.conf_q[`SDC_CONF_GN_HI:`SDC_CONF_GN_LO] != 3'h0;
  assign clkdiv  = s_q.conf_q[`SDC_CONF_CLKDIV];

  // Settling time in output periods
  always_comb begin
    if (chop) begin
      settle = `SDC_SET_CHOP;
    end else if (third_order_filter_select) begin
      settle = `SDC_SET_THIRD_ORDER_FILTER_SELECT;
    end else begin
      settle = `SDC_SET_SINC4;
    end
  end

  // Calibration length for the mode currently programmed
  always_comb begin
    cal_len = settle;
    if (op == SDC_OP_IFS) begin
      cal_len = settle << (5'(gain_hi) + 5'(clkdiv));
    end
  end

  // ****************************************
  // Scaling datapath
  // ****************************************
  // Offset binary codes; gain of one when the full-scale word is 2^22
  assign diff = $signed({1'b0, RAW_SAMPLE}) - $signed({1'b0, s_q.off_q});
  assign prod = diff * $signed({1'b0, s_q.full_q});
  assign shf  = prod >>> `SDC_GAIN_SHIFT;

  always_comb begin
    if (shf > 50'sh0007fffff) begin
      scaled = 24'hffffff;
    end else if (shf < -50'sh000800000) begin
      scaled = 24'h000000;
    end else begin
      scaled = shf[23:0] + `SDC_MID_CODE;
    end
  end

  // ****************************************
  // Period counter
  // ****************************************
  assign tick = (s_q.st_q == SDC_ST_CONV || s_q.st_q == SDC_ST_CAL) && s_q.per_q == 20'h00001;
  assign last = tick && s_q.left_q == 5'h01;

  assign acc = (AVS_IN.read || AVS_IN.write) && s_q.ack_q;
  assign wr  = acc && AVS_IN.write;
  assign rd  = acc && AVS_IN.read;

  assign stat = {24'h000000, s_q.ready_n_q, s_q.st_q == SDC_ST_CAL, s_q.st_q,
                 s_q.conf_q[`SDC_CONF_CH_HI:`SDC_CONF_CH_LO]};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic       restart;
    logic [2:0] new_op;
    logic [4:0] len;
    s_d             = s_q;
    restart         = 1'b0;
    new_op          = 3'h0;
    len             = 5'h00;
    s_d.filt_rst_q  = 1'b0;
    s_d.conv_done_q = 1'b0;
    s_d.cs_n_m_q    = CS_N;
    s_d.cs_n_s_q    = s_q.cs_n_m_q;
    s_d.ack_q       = (AVS_IN.read || AVS_IN.write) && !s_q.ack_q;

    // ****************************************
    // Read data
    // ****************************************
    // Captured on the first request cycle, so it stands at the edge where waitrequest is low
    case (AVS_IN.address)
      `SDC_OFS_MODE:   s_d.rdata_q = s_q.mode_q;
      `SDC_OFS_CONF:   s_d.rdata_q = s_q.conf_q;
      `SDC_OFS_STAT:   s_d.rdata_q = stat;
      `SDC_OFS_DATA:   s_d.rdata_q = {8'h00, s_q.data_q};
      `SDC_OFS_OFFSET: s_d.rdata_q = {8'h00, s_q.off_q};
      `SDC_OFS_FULL:   s_d.rdata_q = {8'h00, s_q.full_q};
      default:         s_d.rdata_q = 32'h00000000;
    endcase

    // Reading the result marks it consumed until the next one
    if (rd && AVS_IN.address == `SDC_OFS_DATA) begin
      s_d.ready_n_q = 1'b1;
    end

    if (tick) begin
      s_d.per_q  = per_len;
      s_d.left_q = s_q.left_q - 5'h01;
    end else if (s_q.st_q == SDC_ST_CONV || s_q.st_q == SDC_ST_CAL) begin
      s_d.per_q = s_q.per_q - 20'h00001;
    end

    // ****************************************
    // Completion
    // ****************************************
    if (last && s_q.st_q == SDC_ST_CONV) begin
      s_d.data_q      = scaled;
      s_d.ready_n_q   = 1'b0;
      s_d.conv_done_q = 1'b1;
      s_d.left_q      = zlat ? settle : 5'h01;
      if (op == SDC_OP_SINGLE) begin
        s_d.st_q = SDC_ST_IDLE;
        s_d.mode_q[`SDC_MODE_OP_HI:`SDC_MODE_OP_LO] = SDC_OP_IDLE;
      end
    end

    if (last && s_q.st_q == SDC_ST_CAL) begin
      // Full-scale word from a calibration keeps the gain-of-one scale
      if (op == SDC_OP_IZS || op == SDC_OP_SZS) begin
        s_d.off_q = RAW_SAMPLE;
      end else begin
        s_d.full_q = RAW_SAMPLE >> 1;
      end
      s_d.ready_n_q = 1'b0;
      s_d.ref_q     = 2'h0;
      s_d.st_q      = SDC_ST_IDLE;
      s_d.mode_q[`SDC_MODE_OP_HI:`SDC_MODE_OP_LO] = SDC_OP_IDLE;
    end

    // ****************************************
    // Register writes
    // ****************************************
    if (wr) begin
      case (AVS_IN.address)
        `SDC_OFS_MODE: begin
          s_d.mode_q = AVS_IN.writedata;
          new_op     = AVS_IN.writedata[`SDC_MODE_OP_HI:`SDC_MODE_OP_LO];
          restart    = 1'b1;
        end
        `SDC_OFS_CONF: begin
          s_d.conf_q = AVS_IN.writedata;
          new_op     = op;
          // A configuration write during conversion resets the filter, as a channel change does
          restart    = s_q.st_q == SDC_ST_CONV;
        end
        `SDC_OFS_OFFSET: begin
          if (s_q.st_q == SDC_ST_IDLE || s_q.st_q == SDC_ST_PDOWN) begin
            s_d.off_q = AVS_IN.writedata[23:0];
          end
        end
        `SDC_OFS_FULL: begin
          if (s_q.st_q == SDC_ST_IDLE || s_q.st_q == SDC_ST_PDOWN) begin
            s_d.full_q = AVS_IN.writedata[23:0];
          end
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // Restart
    // ****************************************
    if (restart) begin
      s_d.ref_q = 2'h0;
      case (sdc_op_type'(new_op))
        SDC_OP_IDLE: begin
          s_d.st_q = SDC_ST_IDLE;
        end
        SDC_OP_PDOWN: begin
          s_d.st_q = SDC_ST_PDOWN;
        end
        SDC_OP_CONT, SDC_OP_SINGLE: begin
          s_d.st_q = SDC_ST_CONV;
          len      = settle;
        end
        default: begin
          s_d.st_q = SDC_ST_CAL;
          if (new_op == SDC_OP_IZS) begin
            s_d.ref_q = 2'h1;
          end else if (new_op == SDC_OP_IFS) begin
            s_d.ref_q = 2'h2;
          end
        end
      endcase
      if (s_d.st_q == SDC_ST_CONV || s_d.st_q == SDC_ST_CAL) begin
        s_d.per_q      = per_len;
        s_d.left_q     = len;
        s_d.filt_rst_q = 1'b1;
        s_d.ready_n_q  = 1'b1;
      end
    end

    // ****************************************
    // Period and length load
    // ****************************************
    // Period and length depend on the settings just written, so both load one cycle after the restart;
    // the same load gives a clean first period after reset
    if (s_q.filt_rst_q && (s_q.st_q == SDC_ST_CONV || s_q.st_q == SDC_ST_CAL)) begin
      s_d.per_q = per_len;
      if (s_q.st_q == SDC_ST_CAL) begin
        s_d.left_q = cal_len;
      end else begin
        s_d.left_q = settle;
      end
    end

    // ****************************************
    // Reset
    // ****************************************
    if (SRST) begin
      s_d            = '0;
      s_d.st_q       = SDC_ST_CONV;
      s_d.mode_q     = `SDC_MODE_RST;
      s_d.conf_q     = `SDC_CONF_RST;
      s_d.off_q      = `SDC_OFF_RST;
      s_d.full_q     = `SDC_FULL_RST;
      // Counter stays clear; it loads from the filter word in the first cycle after release
      s_d.ready_n_q  = 1'b1;
      s_d.filt_rst_q = 1'b1;
      s_d.cs_n_m_q   = 1'b1;
      s_d.cs_n_s_q   = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    s_q <= s_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign AVS_READDATA    = s_q.rdata_q;
  assign AVS_WAITREQUEST = (AVS_IN.read || AVS_IN.write) && !s_q.ack_q;
  assign RDY_PIN_O       = s_q.ready_n_q;
  assign RDY_PIN_OE      = !s_q.cs_n_s_q;
  assign REF_SEL         = s_q.ref_q;
  assign FILT_RST        = s_q.filt_rst_q;
  assign CONV_DONE       = s_q.conv_done_q;
endmodule

// File: test/sdc_front_model.sv
// Converter front end: what reaches the converter for each reference setting
`timescale 1ns/1ps
module sdc_front_model #(
  parameter logic [23:0] ZERO_REF = 24'h0012a5, // Arbitrary level
  parameter logic [23:0] FULL_REF = 24'hf3c0de  // Arbitrary level
) (
  input  wire logic [1:0]  ref_sel,
  input  wire logic [23:0] pin_level,
  output      logic [23:0] raw
);
  always_comb begin
    raw = (ref_sel == 2'h1) ? ZERO_REF : (ref_sel == 2'h2) ? FULL_REF : pin_level;
  end
endmodule

// File: test/sdc_top_properties.sv
// Port-level timing checks of the calibration and filter timing block
`timescale 1ns/1ps
module sdc_checker (
  input wire logic                    CLK,
  input wire logic                    SRST,
  input wire sdc_pkg::sdc_avs_in_type AVS_IN,
  input wire logic [31:0]             AVS_READDATA,
  input wire logic                    AVS_WAITREQUEST,
  input wire logic                    CS_N,
  input wire logic                    RDY_PIN_O,
  input wire logic                    RDY_PIN_OE,
  input wire logic [1:0]              REF_SEL,
  input wire logic                    FILT_RST,
  input wire logic                    CONV_DONE
);
  import sdc_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic rq;
  logic mw;
  assign rq = AVS_IN.read | AVS_IN.write;
  assign mw = AVS_IN.write & !AVS_WAITREQUEST & (AVS_IN.address == 4'h0);
  AST_WAIT_FIRST: assert property ($rose(rq) |-> AVS_WAITREQUEST) else $error("no wait on first cycle");
  AST_WAIT_END: assert property (rq && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("late answer");
  AST_UNMAPPED: assert property (AVS_IN.read && !AVS_WAITREQUEST && AVS_IN.address > 4'h5
    |-> AVS_READDATA == 32'h0) else $error("unmapped read not zero");
  // Idle and power-down writes start nothing, so no filter reset follows them
  AST_RESTART: assert property (mw && AVS_IN.writedata[23:22] != 2'h1 |=> FILT_RST)
    else $error("no filter reset on run or cal start");
  AST_FRST_PULSE: assert property (FILT_RST |=> !FILT_RST) else $error("filter reset too long");
  AST_DONE_PULSE: assert property (CONV_DONE |=> !CONV_DONE) else $error("done too long");
  AST_CAL_BUSY: assert property (mw && AVS_IN.writedata[23] |=> RDY_PIN_O) else $error("ready at cal start");
  AST_REF_ZERO: assert property (mw && AVS_IN.writedata[23:21] == 3'h4 |=> REF_SEL == 2'h1)
    else $error("zero ref not routed");
  AST_REF_FULL: assert property (mw && AVS_IN.writedata[23:21] == 3'h5 |=> REF_SEL == 2'h2)
    else $error("full ref not routed");
  AST_REF_PINS: assert property (mw && AVS_IN.writedata[23:22] == 2'h3 |=> REF_SEL == 2'h0)
    else $error("system cal not on pins");
  AST_OE_OFF: assert property (CS_N [*4] |-> !RDY_PIN_OE) else $error("pin driven while deselected");
  AST_OE_ON: assert property (!CS_N [*4] |-> RDY_PIN_OE) else $error("pin not driven while selected");
endmodule

// File: test/test_sdc_top.sv
// Self-checking bench for the calibration and filter timing block
`timescale 1ns/1ps
module test_sdc_top;
  import sdc_pkg::*;
  localparam logic [23:0] ZREF = 24'h0012a5;
  localparam logic [23:0] FREF = 24'hf3c0de;
  localparam int          P    = 1024;
  logic           CLK  = 1'b0;
  logic           SRST = 1'b1;
  logic           CS_N = 1'b1;
  sdc_avs_in_type avs  = '0;
  logic [23:0]    pin  = 24'h0;
  logic [23:0]    raw, p1, p2, p3, wofs;
  logic [31:0]    rdata;
  logic [1:0]     ref_sel;
  logic           wait_r, rdy_o, rdy_oe, filt_rst, conv_done;
  logic [31:0]    exp_q[$];
  int             err_total = 0;
  int             cmp_count = 0;
  int             seed      = 85519;
  always #5 CLK = ~CLK;
  sdc_top dut (.CLK(CLK), .SRST(SRST), .AVS_IN(avs), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r),
    .RAW_SAMPLE(raw), .CS_N(CS_N), .RDY_PIN_O(rdy_o), .RDY_PIN_OE(rdy_oe), .REF_SEL(ref_sel),
    .FILT_RST(filt_rst), .CONV_DONE(conv_done));
  sdc_front_model #(.ZERO_REF(ZREF), .FULL_REF(FREF)) fe (.ref_sel(ref_sel), .pin_level(pin), .raw(raw));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Held until waitrequest is seen low at a rising edge, released on that edge
  task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
    int   n;
    logic w;
    @(posedge CLK);
    avs <= '{address: a, read: !wr, write: wr, writedata: d};
    for (n = 0; n < 50; n++) begin
      @(negedge CLK);
      w = wait_r;
      @(posedge CLK);
      if (w === 1'b0) break;
    end
    avs <= '0;
    if (n == 50) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  // Cycles to a result pulse, or to the ready pin falling; two cycles of slack
  task automatic gap(input int e, input logic on_done);
    int n;
    for (n = 1; n < 70000; n++) begin
      @(negedge CLK);
      if (on_done ? conv_done === 1'b1 : rdy_o === 1'b0) break;
    end
    if (n == 70000) begin
      err_total++;
      tally_and_finish;
    end
    check((n >= e - 2 && n <= e + 2) ? e : n, e);
  endtask
  function automatic logic [23:0] scale(input logic [23:0] r, input logic [23:0] o, input logic [23:0] f);
    logic signed [51:0] t;
    t = ($signed({1'b0, r}) - $signed({1'b0, o})) * $signed({1'b0, f});
    t = (t >>> 22) + 52'sh800000;
    return (t < 0) ? 24'h0 : (t > 52'shffffff) ? 24'hffffff : t[23:0];
  endfunction
  always @(negedge CLK) begin
    if (avs.read && wait_r === 1'b0) begin
      check(rdata, exp_q.pop_front());
    end
  end
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    rd(4'h0, 32'h00000060);
    rd(4'h1, 32'h0);
    rd(4'h4, 32'h00800000);
    rd(4'h5, 32'h00400000);
    rd(4'h7, 32'h0);
    CS_N <= 1'b0;
    bus(4'h0, 1'b1, 32'h00000001);
    gap(4 * P, 1'b1);
    gap(P, 1'b1);
    bus(4'h1, 1'b1, 32'h00000300);
    gap(4 * P, 1'b1);
    bus(4'h0, 1'b1, 32'h00000801);
    gap(4 * P, 1'b1);
    gap(4 * P, 1'b1);
    bus(4'h0, 1'b1, 32'h00008001);
    gap(3 * P, 1'b1);
    bus(4'h1, 1'b1, 32'h00000301);
    bus(4'h0, 1'b1, 32'h00800001);
    rd(4'h2, 32'h000000e3);
    gap(2 * P - 2, 1'b0);
    rd(4'h2, 32'h00000003);
    rd(4'h4, {8'h0, ZREF});
    bus(4'h1, 1'b1, 32'h00000300);
    // System zero-scale first, then system full-scale; the full-scale word is half the pin level and does not use the offset
    p1 = 24'($random(seed));
    pin <= p1;
    bus(4'h0, 1'b1, 32'h00c00001);
    gap(4 * P, 1'b0);
    rd(4'h4, {8'h0, p1});
    p2 = 24'($random(seed));
    pin <= p2;
    bus(4'h0, 1'b1, 32'h00e00001);
    gap(4 * P, 1'b0);
    rd(4'h5, {9'h0, p2[23:1]});
    // Chop on halves the internal full-scale time, keeping both gain cases inside the run budget
    bus(4'h1, 1'b1, 32'h00000301);
    bus(4'h0, 1'b1, 32'h00a00010);
    gap(2 * 16 * P, 1'b0);
    rd(4'h5, {9'h0, FREF[23:1]});
    // Higher gain doubles it: still busy after one settling time, then stopped by an idle write
    bus(4'h1, 1'b1, 32'h00000305);
    bus(4'h0, 1'b1, 32'h00a00010);
    repeat (2 * 16 * P + 4) @(negedge CLK);
    check(rdy_o, 32'h1);
    bus(4'h0, 1'b1, 32'h00400010);
    bus(4'h1, 1'b1, 32'h00000300);
    wofs = 24'($random(seed));
    p3 = 24'($random(seed));
    bus(4'h4, 1'b1, {8'h0, wofs});
    rd(4'h4, {8'h0, wofs});
    pin <= p3;
    bus(4'h0, 1'b1, 32'h00000001);
    bus(4'h4, 1'b1, 32'h0);
    rd(4'h4, {8'h0, wofs});
    gap(4 * P - 4, 1'b1);
    rd(4'h3, {8'h0, scale(p3, wofs, FREF >> 1)});
    tally_and_finish;
  end
endmodule
bind sdc_top sdc_checker chk (.CLK(CLK), .SRST(SRST), .AVS_IN(AVS_IN), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CS_N(CS_N), .RDY_PIN_O(RDY_PIN_O), .RDY_PIN_OE(RDY_PIN_OE),
  .REF_SEL(REF_SEL), .FILT_RST(FILT_RST), .CONV_DONE(CONV_DONE));
